// File: core/ior_pkg.sv
package ior_pkg;

  // Instruction word layout
  localparam int          INSTR_W        = 16;
  localparam int          DATA_W         = 8;
  localparam int          DEST_BIT       = 8;
  localparam logic [6:0]  REG_OR_PATTERN = 7'h04;
  localparam logic [7:0]  LIT_OR_PATTERN = 8'hB3;

  // Reset values
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic        ZERO_RESET     = 1'b0;
  localparam logic [15:0] INSTR_RESET    = 16'h0000;

  // Phases of one instruction cycle, idle between instructions
  typedef enum logic [2:0]
  {
    IOR_IDLE = 3'b000,
    IOR_Q1   = 3'b001,
    IOR_Q2   = 3'b010,
    IOR_Q3   = 3'b011,
    IOR_Q4   = 3'b100
  } ior_phase_type;

  // Decoded instruction class
  typedef enum logic [1:0]
  {
    IOR_NONE = 2'b00,
    IOR_LIT  = 2'b01,
    IOR_REG  = 2'b10
  } ior_kind_type;

  // Instruction class from the raw word
  function automatic ior_kind_type ior_decode(input logic [15:0] word);
    ior_kind_type k;
    k = IOR_NONE;
    if (word[15:9] == REG_OR_PATTERN)
      k = IOR_REG;
    else if (word[15:8] == LIT_OR_PATTERN)
      k = IOR_LIT;
    return k;
  endfunction

endpackage

// File: core/ior_or_unit.sv
module ior_or_unit
  import ior_pkg::*;
#(
  parameter int WIDTH = DATA_W
)
(
  // Operands
  input  wire logic [WIDTH-1:0] operand_a,
  input  wire logic [WIDTH-1:0] operand_b,
  // Result
  output logic      [WIDTH-1:0] result,
  output logic                  result_zero
);

  // Bitwise inclusive OR and its zero test
  always_comb
  begin
    result      = operand_a | operand_b;
    result_zero = ((operand_a | operand_b) == '0);
  end

endmodule

// File: core/ior_exec.sv
module ior_exec
  import ior_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Instruction from the decoder
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_word,
  output logic                    instr_ready,
  // File register port
  output logic      [DATA_W-1:0]  file_addr,
  output logic                    file_rd_en,
  input  wire logic [DATA_W-1:0]  file_rd_data,
  output logic                    file_wr_en,
  output logic      [DATA_W-1:0]  file_wr_data,
  // Core state
  output logic      [DATA_W-1:0]  working_accumulator,
  output logic                    zero_flag,
  // Completion
  output logic                    instr_done,
  output logic                    instr_unsupported
);

  ior_phase_type      phase_q;
  ior_phase_type      phase_d;
  ior_kind_type       kind_q;
  ior_kind_type       kind_d;
  logic [INSTR_W-1:0] instr_q;
  logic [INSTR_W-1:0] instr_d;
  logic [DATA_W-1:0]  acc_q;
  logic [DATA_W-1:0]  acc_d;
  logic               zero_q;
  logic               zero_d;
  logic [DATA_W-1:0]  result_q;
  logic [DATA_W-1:0]  result_d;
  logic               res_zero_q;
  logic               res_zero_d;
  logic [DATA_W-1:0]  src_operand;
  logic [DATA_W-1:0]  or_result;
  logic               or_zero;
  logic               dest_file;

  // Destination bit of the held instruction
  assign dest_file = instr_q[DEST_BIT];

  // Second operand: the file read data, or the immediate for the literal form
  always_comb
  begin
    if (kind_q == IOR_REG)
      src_operand = file_rd_data;
    else
      src_operand = instr_q[DATA_W-1:0];
  end

  ior_or_unit #(
    .WIDTH       (DATA_W)
  ) ior_or_unit_inst (
    .operand_a   (acc_q),
    .operand_b   (src_operand),
    .result      (or_result),
    .result_zero (or_zero)
  );

  // Phase sequencer and datapath next values
  always_comb
  begin
    phase_d    = phase_q;
    kind_d     = kind_q;
    instr_d    = instr_q;
    acc_d      = acc_q;
    zero_d     = zero_q;
    result_d   = result_q;
    res_zero_d = res_zero_q;
    case (phase_q)
      IOR_IDLE:
      begin
        if (instr_valid)
        begin
          instr_d = instr_word;
          phase_d = IOR_Q1;
        end
      end
      IOR_Q1:
      begin
        kind_d  = ior_decode(instr_q);
        phase_d = IOR_Q2;
      end
      IOR_Q2:
      begin
        phase_d = IOR_Q3;
      end
      IOR_Q3:
      begin
        result_d   = or_result;
        res_zero_d = or_zero;
        phase_d    = IOR_Q4;
      end
      IOR_Q4:
      begin
        // Unrecognised words leave the accumulator and flag alone
        if (kind_q == IOR_LIT || (kind_q == IOR_REG && !dest_file))
          acc_d = result_q;
        if (kind_q != IOR_NONE)
          zero_d = res_zero_q;
        phase_d = IOR_IDLE;
      end
      default:
      begin
        phase_d = IOR_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q    <= IOR_IDLE;
      kind_q     <= IOR_NONE;
      instr_q    <= INSTR_RESET;
      acc_q      <= ACC_RESET;
      zero_q     <= ZERO_RESET;
      result_q   <= ACC_RESET;
      res_zero_q <= ZERO_RESET;
    end
    else
    begin
      phase_q    <= phase_d;
      kind_q     <= kind_d;
      instr_q    <= instr_d;
      acc_q      <= acc_d;
      zero_q     <= zero_d;
      result_q   <= result_d;
      res_zero_q <= res_zero_d;
    end
  end

  // Strobes; read in Q2 so the file answers by Q3
  assign instr_ready       = (phase_q == IOR_IDLE);
  assign file_addr         = instr_q[DATA_W-1:0];
  assign file_rd_en        = (phase_q == IOR_Q2) && (kind_q == IOR_REG);
  assign file_wr_en        = (phase_q == IOR_Q4) && (kind_q == IOR_REG)
                             && dest_file;
  assign file_wr_data      = result_q;
  assign working_accumulator = acc_q;
  assign zero_flag         = zero_q;
  assign instr_done        = (phase_q == IOR_Q4);
  assign instr_unsupported = (phase_q == IOR_Q4) && (kind_q == IOR_NONE);

  // Checks, all on the core clock; reset silences them
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence four_phases_s;
    phase_q == IOR_Q1 ##1 phase_q == IOR_Q2 ##1 phase_q == IOR_Q3
      ##1 phase_q == IOR_Q4;
  endsequence

  // Word taken at the edge where the sequencer is idle
  sequence accept_s;
    phase_q == IOR_IDLE && instr_valid;
  endsequence

  one_cycle_flow_a: assert property (
    accept_s |=> four_phases_s ##1 phase_q == IOR_IDLE)
    else $error("instruction did not finish in four phases");

  reg_decode_a: assert property (
    (accept_s and (instr_word[15:9] == REG_OR_PATTERN))
      |-> ##2 kind_q == IOR_REG && file_rd_en
          && file_addr == $past(instr_word[7:0], 2))
    else $error("register form not decoded or not read");

  or_value_a: assert property (
    phase_q == IOR_Q3 && kind_q != IOR_NONE
      |=> result_q == ($past(acc_q) | $past(src_operand)))
    else $error("result is not the OR of its operands");

  dest_acc_a: assert property (
    phase_q == IOR_Q4 && kind_q == IOR_REG && !dest_file
      |-> !file_wr_en ##1 acc_q == $past(result_q))
    else $error("accumulator destination not honoured");

  dest_file_a: assert property (
    phase_q == IOR_Q4 && kind_q == IOR_REG && dest_file
      |-> file_wr_en && file_wr_data == result_q
          ##1 $stable(acc_q))
    else $error("file destination not honoured");

  zero_flag_a: assert property (
    instr_done && kind_q != IOR_NONE
      |=> zero_flag == ($past(result_q) == '0))
    else $error("zero flag does not match result");

  literal_acc_a: assert property (
    phase_q == IOR_Q4 && kind_q == IOR_LIT
      |-> !file_wr_en ##1 acc_q == $past(result_q))
    else $error("literal result not placed in accumulator");

  unsupported_quiet_a: assert property (
    instr_unsupported |-> !file_wr_en ##1 $stable(acc_q) && $stable(zero_q))
    else $error("unrecognised word changed state");

  // Words offered while busy are ignored, the held word stays put
  busy_refuse_a: assert property (
    phase_q != IOR_IDLE |=> instr_q == $past(instr_q))
    else $error("held instruction changed while busy");

  // Completion strobe lasts one cycle, then the handshake reopens
  done_pulse_a: assert property (
    instr_done |=> !instr_done && instr_ready)
    else $error("completion strobe lasted more than one cycle");

  // File reads only for the register form, and only in Q2
  read_only_q2_a: assert property (
    file_rd_en |-> phase_q == IOR_Q2 && kind_q == IOR_REG)
    else $error("file read strobe outside register form Q2");

  // Literal form never touches the file port once decoded
  literal_no_file_a: assert property (
    kind_q == IOR_LIT && phase_q != IOR_IDLE && phase_q != IOR_Q1
      |-> !file_rd_en && !file_wr_en)
    else $error("literal form drove the file port");

endmodule

// File: bench/ior_exec_test.sv
module ior_exec_test
  import ior_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic        wr;
    logic [7:0]  wd;
    logic [7:0]  ad;
    logic [7:0]  acc;
    logic        z;
    logic        un;
    logic [63:0] t;
  } ior_note_type;

  logic               clk;
  logic               resetn;
  logic               instr_valid;
  logic [INSTR_W-1:0] instr_word;
  logic               instr_ready;
  logic [DATA_W-1:0]  file_addr;
  logic               file_rd_en;
  logic [DATA_W-1:0]  file_rd_data;
  logic               file_wr_en;
  logic [DATA_W-1:0]  file_wr_data;
  logic [DATA_W-1:0]  working_accumulator;
  logic               zero_flag;
  logic               instr_done;
  logic               instr_unsupported;
  logic [7:0]         mem [256];
  logic [7:0]         ref_mem [256];
  logic [7:0]         ref_acc;
  logic               ref_z;
  ior_note_type       q [$];
  int                 n_fail;
  int                 compares;

  ior_exec ior_exec_inst (
    .clk                 (clk),
    .resetn              (resetn),
    .instr_valid         (instr_valid),
    .instr_word          (instr_word),
    .instr_ready         (instr_ready),
    .file_addr           (file_addr),
    .file_rd_en          (file_rd_en),
    .file_rd_data        (file_rd_data),
    .file_wr_en          (file_wr_en),
    .file_wr_data        (file_wr_data),
    .working_accumulator (working_accumulator),
    .zero_flag           (zero_flag),
    .instr_done          (instr_done),
    .instr_unsupported   (instr_unsupported)
  );

  // Clock, 100 ns period
  always #50 clk = ~clk;

  task automatic check(input string what, input logic [63:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Model result noted, then word held until the design takes it
  task automatic issue(input logic [15:0] w);
    ior_note_type n;
    logic         rf;
    logic [7:0]   r;
    int           k;
    n = '0;
    rf = (w[15:9] == 7'h04);
    n.un = !(rf || w[15:8] == 8'hB3);
    r = ref_acc | (rf ? ref_mem[w[7:0]] : w[7:0]);
    if (!n.un)
      ref_z = (r == 8'h00);
    if (rf && w[8])
    begin
      n = '{1'b1, r, w[7:0], 8'h00, 1'b0, 1'b0, 64'd0};
      ref_mem[w[7:0]] = r;
    end
    else if (!n.un)
      ref_acc = r;
    n.acc = ref_acc;
    n.z = ref_z;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (instr_ready !== 1'b1 && k < 20);
    check("accept", instr_ready === 1'b1, 1);
    instr_valid <= 1'b0;
    instr_word <= 16'($urandom);
    n.t = $time;
    q.push_back(n);
  endtask

  task automatic drain(input string name);
    int k;
    k = 0;
    while (q.size() != 0 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    check("drain", q.size() == 0, 1);
    repeat (2) @(posedge clk);
    $display("test %s done", name);
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    ref_acc = 8'h00;
    ref_z = 1'b0;
  endtask

  // File register stand-in; data scrambled when not being read
  always @(posedge clk)
  begin
    file_rd_data <= (file_rd_en === 1'b1) ? mem[file_addr] : 8'($urandom);
    if (file_wr_en === 1'b1)
      mem[file_addr] <= file_wr_data;
  end

  // Oldest note checked at each completion, state one cycle later
  initial forever
  begin : watch
    ior_note_type n;
    @(negedge clk);
    if (instr_done === 1'b1)
    begin
      check("pending", q.size() != 0, 1);
      n = q.pop_front();
      check("latency", $time - n.t, 350);
      check("unsupported", instr_unsupported, n.un);
      check("wr_en", file_wr_en, n.wr);
      check("wr_data", file_wr_en === 1'b1 ? file_wr_data : 0, n.wd);
      check("wr_addr", file_wr_en === 1'b1 ? file_addr : 0, n.ad);
      @(negedge clk);
      check("acc", working_accumulator, n.acc);
      check("zero", zero_flag, n.z);
    end
  end

  // Watchdog far beyond the expected run
  initial
  begin
    #(20000 * 100);
    n_fail++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_sim();
  end

  // Main sequence
  initial
  begin : main
    logic [15:0] w;
    clk = 0;
    resetn = 0;
    instr_valid = 0;
    instr_word = 0;
    n_fail = 0;
    compares = 0;
    void'($urandom(32'ha7cf));
    foreach (mem[i])
    begin
      mem[i] = 8'($urandom);
      ref_mem[i] = mem[i];
    end
    mem[8'h40] = 8'h00;
    ref_mem[8'h40] = 8'h00;
    do_reset();
    issue(16'hB300);
    issue(16'hB39A);
    issue(16'hB335);
    drain("literal");
    issue(16'h0812);
    issue(16'h09FF);
    issue(16'h0800);
    issue(16'h0A12);
    issue(16'hB200);
    issue(16'h2A12);
    drain("register");
    // Zero result through the register form needs a cleared accumulator
    do_reset();
    issue(16'h0940);
    issue(16'hB300);
    drain("mid reset");
    repeat (40)
    begin
      w = 16'($urandom);
      case ($urandom % 3)
        0: w[15:9] = 7'h04;
        1: w[15:8] = 8'hB3;
        default: ;
      endcase
      issue(w);
    end
    drain("random");
    check("left over", q.size(), 0);
    end_sim();
  end
endmodule
